// >>> design/dim_pkg.sv
package dim_pkg;

   // ---------------------------------------------------------------
   // Clock and counter widths
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CNT_W         = 16;

   // ---------------------------------------------------------------
   // Pin timing, times in ns, counts in clock cycles
   // ---------------------------------------------------------------
   localparam int DETECT_DELAY_NS = 100_000;
   localparam int DETECT_LOW_NS   = 260_000;
   localparam int DETECT_WIN_NS   = 1_000_000;
   localparam int SHUTDOWN_NS     = 2_500_000;
   localparam int ACK_HOLD_NS     = 512_000;
   localparam int DETECT_DELAY_CYC = (DETECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DETECT_LOW_CYC   = (DETECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DETECT_WIN_CYC   = DETECT_WIN_NS / CLK_PERIOD_NS;
   localparam int SHUTDOWN_CYC     = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_HOLD_CYC     = ACK_HOLD_NS / CLK_PERIOD_NS;
   localparam int ACK_GAP_CYC      = 200;
   localparam int SHUTDOWN_MARGIN  = 16;
   localparam int ENTRY_HIGH_CYC   = DETECT_DELAY_CYC + 500;
   localparam int ENTRY_LOW_CYC    = DETECT_LOW_CYC + 400;
   localparam int START_CYC        = 40;
   localparam int EOS_CYC          = 40;
   localparam int BIT_QUARTER_CYC  = 50;
   localparam int ACK_SKIP_CYC     = 4;
   localparam int ACK_WATCH_CYC    = 2 * ACK_GAP_CYC;

   // ---------------------------------------------------------------
   // Frame layout and reference steps
   // ---------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR     = 8'h72;
   localparam int         FRAME_BITS   = 16;
   localparam int         ACK_REQ_BIT  = 7;
   localparam int         SUB_HI_BIT   = 6;
   localparam int         SUB_LO_BIT   = 5;
   localparam logic [4:0] STEP_DEFAULT = 5'h1F;
   localparam logic [7:0] FULL_MV      = 8'hC8;

   // ---------------------------------------------------------------
   // Host register map
   // ---------------------------------------------------------------
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] CMD_OFS      = 8'h04;
   localparam logic [7:0] STATUS_OFS   = 8'h08;
   localparam int         CTRL_EN_BIT  = 0;
   localparam int         CTRL_WIRE_BIT = 1;
   localparam int         CTRL_PWM_BIT = 2;
   localparam int         CTRL_DUTY_LSB = 8;

   function automatic logic [CNT_W-1:0] incSat(input logic [CNT_W-1:0] v);
      incSat = (&v) ? v : v + 16'h0001;
   endfunction

endpackage

// >>> design/dimming_device.sv
`timescale 1ns/1ps
`default_nettype none
module dimming_device #(
   parameter int WIN_CYC  = dim_pkg::DETECT_WIN_CYC,
   parameter int SHDN_CYC = dim_pkg::SHUTDOWN_CYC,
   parameter int ACK_CYC  = dim_pkg::ACK_HOLD_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset,
   dimming_link_if.device  link,
   output logic            active,
   output logic            oneWire,
   output logic [4:0]      stepCode,
   output logic [7:0]      refMv
);
   import dim_pkg::*;

   typedef enum logic [1:0] {OFF, DETECT, PWM, WIRE} mode_type;
   typedef enum logic [2:0] {RX_IDLE, RX_LOW, RX_HIGH, RX_GAP, RX_ACK} rx_type;

   // ---------------------------------------------------------------
   // Step table
   // ---------------------------------------------------------------
   function automatic logic [7:0] stepMv(input logic [4:0] c);
      logic [7:0] w;
      w = {3'b000, c};
      if (c == 5'h00)
         stepMv = 8'h00;
      else if (c <= 5'h0C)
         stepMv = 8'(8'h02 + 8'(3 * w));
      else if (c <= 5'h17)
         stepMv = 8'(8'(6 * w) - 8'h22);
      else
         stepMv = 8'(8'(12 * w) - 8'hAC);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchroniser and edges
   // ---------------------------------------------------------------
   logic pinMeta_q;
   logic pinSync_q;
   logic pinPrev_q;
   wire  pinFall = pinPrev_q & ~pinSync_q;
   wire  pinRise = ~pinPrev_q & pinSync_q;

   always_ff @(posedge clk)
   begin
      pinMeta_q <= link.pinLevel;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
   end

   // ---------------------------------------------------------------
   // Mode detection
   // ---------------------------------------------------------------
   mode_type         mode_q;
   mode_type         mode_d;
   logic [CNT_W-1:0] winCnt_q;
   logic [CNT_W-1:0] lowRun_q;
   logic             armed_q;
   logic             pull_q;

   wire shutdownHit = (mode_q != OFF) && (lowRun_q >= CNT_W'(SHDN_CYC));
   wire pastDelay   = winCnt_q >= CNT_W'(DETECT_DELAY_CYC);
   wire winOver     = winCnt_q >= CNT_W'(WIN_CYC);
   wire entryMet    = armed_q && !pinSync_q && !winOver
                      && (lowRun_q > CNT_W'(DETECT_LOW_CYC));

   always_comb
   begin
      mode_d = mode_q;
      if (shutdownHit)
         mode_d = OFF;
      else
         unique case (mode_q)
            OFF:    if (pinSync_q) mode_d = DETECT;
            DETECT: if (entryMet) mode_d = WIRE;
                    else if (winOver) mode_d = PWM;
            PWM:    mode_d = PWM;
            WIRE:   mode_d = WIRE;
         endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         mode_q <= OFF;
      else
         mode_q <= mode_d;
   end

   // Own acknowledge pull is not mistaken for a shutdown request
   always_ff @(posedge clk)
   begin
      if (reset || pinSync_q || pull_q)
         lowRun_q <= '0;
      else
         lowRun_q <= incSat(lowRun_q);
   end

   // Low must start after the delay, so arming needs a high past it
   always_ff @(posedge clk)
   begin
      if (reset || mode_q != DETECT)
      begin
         winCnt_q <= '0;
         armed_q  <= 1'b0;
      end
      else
      begin
         winCnt_q <= incSat(winCnt_q);
         if (pinSync_q && pastDelay)
            armed_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // One-wire receiver
   // ---------------------------------------------------------------
   rx_type           rx_q;
   logic [CNT_W-1:0] lenLow_q;
   logic [CNT_W-1:0] lenHigh_q;
   logic [CNT_W-1:0] ackCnt_q;
   logic [15:0]      shift_q;
   logic [4:0]       bitCnt_q;
   logic             decided_q;
   logic [4:0]       step_q;

   wire [15:0] bitsNow  = decided_q ? shift_q : {shift_q[14:0], 1'b0};
   wire [4:0]  cntNow   = decided_q ? bitCnt_q : bitCnt_q + 5'h01;
   wire        frameEnd = cntNow == 5'(FRAME_BITS);
   wire        frameOk  = (bitsNow[15:8] == DEV_ADDR)
                          && (bitsNow[SUB_HI_BIT:SUB_LO_BIT] == 2'b00);
   wire        endFall  = (rx_q == RX_HIGH) && pinFall && frameEnd;
   wire        wantAck  = frameOk && bitsNow[ACK_REQ_BIT];
   wire        oneLong  = !decided_q && (lenHigh_q > lenLow_q);

   always_ff @(posedge clk)
   begin
      if (reset || mode_q != WIRE)
      begin
         rx_q      <= RX_IDLE;
         lenLow_q  <= '0;
         lenHigh_q <= '0;
         ackCnt_q  <= '0;
         shift_q   <= '0;
         bitCnt_q  <= '0;
         decided_q <= 1'b0;
         pull_q    <= 1'b0;
      end
      else
         unique case (rx_q)
            RX_IDLE:
               if (pinFall)
               begin
                  rx_q     <= RX_LOW;
                  lenLow_q <= '0;
               end
            RX_LOW:
            begin
               lenLow_q <= incSat(lenLow_q);
               if (pinRise)
               begin
                  rx_q      <= RX_HIGH;
                  lenHigh_q <= '0;
                  decided_q <= 1'b0;
               end
            end
            RX_HIGH:
            begin
               lenHigh_q <= incSat(lenHigh_q);
               if (pinFall)
               begin
                  shift_q   <= bitsNow;
                  decided_q <= 1'b0;
                  lenLow_q  <= '0;
                  ackCnt_q  <= '0;
                  bitCnt_q  <= frameEnd ? 5'h00 : cntNow;
                  if (!frameEnd)
                     rx_q <= RX_LOW;
                  else if (wantAck)
                     rx_q <= RX_GAP;
                  else
                     rx_q <= RX_IDLE;
               end
               else if (&lenHigh_q)
               begin
                  // Stalled frame: drop what was gathered
                  rx_q     <= RX_IDLE;
                  bitCnt_q <= '0;
               end
               else if (oneLong)
               begin
                  shift_q   <= {shift_q[14:0], 1'b1};
                  bitCnt_q  <= bitCnt_q + 5'h01;
                  decided_q <= 1'b1;
               end
            end
            RX_GAP:
            begin
               ackCnt_q <= incSat(ackCnt_q);
               if (ackCnt_q >= CNT_W'(ACK_GAP_CYC - 1))
               begin
                  rx_q     <= RX_ACK;
                  ackCnt_q <= '0;
                  pull_q   <= 1'b1;
               end
            end
            RX_ACK:
            begin
               ackCnt_q <= incSat(ackCnt_q);
               if (ackCnt_q >= CNT_W'(ACK_CYC - 1))
               begin
                  rx_q   <= RX_IDLE;
                  pull_q <= 1'b0;
               end
            end
            default:
               rx_q <= RX_IDLE;
         endcase
   end

   // Only a power reset restores the step; shutdown keeps it
   always_ff @(posedge clk)
   begin
      if (reset)
         step_q <= STEP_DEFAULT;
      else if (endFall && frameOk)
         step_q <= bitsNow[4:0];
   end

   // ---------------------------------------------------------------
   // Reference selection
   // ---------------------------------------------------------------
   logic [7:0] refMv_q;
   logic       active_q;
   logic       wire_q;

   wire [7:0] pwmMv = pinSync_q ? FULL_MV : 8'h00;
   wire [7:0] refMv_d = (mode_q == WIRE) ? stepMv(step_q) :
                        (mode_q == OFF)  ? 8'h00 : pwmMv;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         refMv_q  <= 8'h00;
         active_q <= 1'b0;
         wire_q   <= 1'b0;
      end
      else
      begin
         refMv_q  <= refMv_d;
         active_q <= mode_q != OFF;
         wire_q   <= mode_q == WIRE;
      end
   end

   assign link.devPullLow = pull_q;
   assign active          = active_q;
   assign oneWire         = wire_q;
   assign stepCode        = step_q;
   assign refMv           = refMv_q;

endmodule
`default_nettype wire

// >>> design/dimming_host.sv
`timescale 1ns/1ps
`default_nettype none
module dimming_host #(
   parameter int SHDN_CYC  = dim_pkg::SHUTDOWN_CYC,
   parameter int BIT_Q_CYC = dim_pkg::BIT_QUARTER_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [dim_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   dimming_link_if.host                link
);
   import dim_pkg::*;

   typedef enum logic [3:0] {H_OFF, H_EN, H_ENTRY, H_PWM, H_READY, H_START,
                             H_BLOW, H_BHIGH, H_EOS, H_ACK} host_type;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   logic        enable_q;
   logic        wireReq_q;
   logic        pwmRun_q;
   logic [7:0]  duty_q;
   logic [7:0]  cmd_q;
   logic        pending_q;
   logic        ackSeen_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   host_type    st_q;

   wire setup   = psel & ~penable;
   wire access  = psel & penable & pready_q;
   wire hitCtrl = paddr == CTRL_OFS;
   wire hitCmd  = paddr == CMD_OFS;
   wire hitStat = paddr == STATUS_OFS;
   wire busy    = pending_q | (st_q != H_READY);
   wire cmdTake = access & pwrite & hitCmd & ~busy;
   wire [31:0] ctrlRd = {16'h0000, duty_q, 5'h00, pwmRun_q, wireReq_q, enable_q};
   wire [31:0] statRd = {28'h000_0000, st_q == H_PWM, st_q == H_READY, ackSeen_q, busy};
   wire [31:0] readMux = hitCtrl ? ctrlRd :
                         hitCmd  ? {24'h00_0000, cmd_q} :
                         hitStat ? statRd : 32'h0000_0000;

   // One wait-free access phase; unmapped offsets answer with an error
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
      else
      begin
         pready_q  <= setup;
         pslverr_q <= setup & ~(hitCtrl | hitCmd | hitStat);
         if (setup)
            prdata_q <= readMux;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         enable_q  <= 1'b0;
         wireReq_q <= 1'b0;
         pwmRun_q  <= 1'b0;
         duty_q    <= 8'hFF;
      end
      else if (access && pwrite && hitCtrl)
      begin
         enable_q  <= pwdata[CTRL_EN_BIT];
         wireReq_q <= pwdata[CTRL_WIRE_BIT];
         pwmRun_q  <= pwdata[CTRL_PWM_BIT];
         duty_q    <= pwdata[CTRL_DUTY_LSB +: 8];
      end
   end

   // ---------------------------------------------------------------
   // Link sequencer
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic [3:0]       bitIdx_q;
   logic [7:0]       pwmCnt_q;
   logic             pull_q;
   logic             pinMeta_q;
   logic             pinSync_q;

   wire [15:0]       frame   = {DEV_ADDR, cmd_q};
   wire              curBit  = frame[bitIdx_q];
   wire [CNT_W-1:0]  lowLen  = CNT_W'(curBit ? BIT_Q_CYC - 1 : 3 * BIT_Q_CYC - 1);
   wire [CNT_W-1:0]  highLen = CNT_W'(curBit ? 3 * BIT_Q_CYC - 1 : BIT_Q_CYC - 1);
   wire              ackLow  = (st_q == H_ACK) && !pinSync_q
                               && (cnt_q > CNT_W'(ACK_SKIP_CYC));

   always_ff @(posedge clk)
   begin
      pinMeta_q <= link.pinLevel;
      pinSync_q <= pinMeta_q;
      pwmCnt_q  <= reset ? 8'h00 : pwmCnt_q + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pending_q <= 1'b0;
         ackSeen_q <= 1'b0;
      end
      else
      begin
         if (cmdTake)
            cmd_q <= pwdata[7:0];
         pending_q <= cmdTake | (pending_q & (st_q != H_READY));
         ackSeen_q <= ackLow | (ackSeen_q & ~cmdTake);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || (!enable_q && st_q != H_OFF))
      begin
         st_q   <= H_OFF;
         cnt_q  <= '0;
         pull_q <= 1'b1;
      end
      else
      begin
         cnt_q <= incSat(cnt_q);
         unique case (st_q)
            H_OFF:
               if (enable_q && cnt_q >= CNT_W'(SHDN_CYC + SHUTDOWN_MARGIN))
               begin
                  st_q   <= H_EN;
                  cnt_q  <= '0;
                  pull_q <= 1'b0;
               end
            H_EN:
               if (!wireReq_q)
                  st_q <= H_PWM;
               else if (cnt_q >= CNT_W'(ENTRY_HIGH_CYC))
               begin
                  st_q   <= H_ENTRY;
                  cnt_q  <= '0;
                  pull_q <= 1'b1;
               end
            H_ENTRY:
               if (cnt_q >= CNT_W'(ENTRY_LOW_CYC))
               begin
                  st_q   <= H_READY;
                  pull_q <= 1'b0;
               end
            H_PWM:
               pull_q <= pwmRun_q && (pwmCnt_q >= duty_q);
            H_READY:
               if (pending_q)
               begin
                  st_q  <= H_START;
                  cnt_q <= '0;
               end
            H_START:
               if (cnt_q >= CNT_W'(START_CYC))
               begin
                  st_q     <= H_BLOW;
                  cnt_q    <= '0;
                  pull_q   <= 1'b1;
                  bitIdx_q <= 4'hF;
               end
            H_BLOW:
               if (cnt_q >= lowLen)
               begin
                  st_q   <= H_BHIGH;
                  cnt_q  <= '0;
                  pull_q <= 1'b0;
               end
            H_BHIGH:
               if (cnt_q >= highLen)
               begin
                  st_q     <= (bitIdx_q == 4'h0) ? H_EOS : H_BLOW;
                  cnt_q    <= '0;
                  pull_q   <= 1'b1;
                  bitIdx_q <= bitIdx_q - 4'h1;
               end
            H_EOS:
               if (cnt_q >= CNT_W'(EOS_CYC - 1))
               begin
                  st_q   <= cmd_q[ACK_REQ_BIT] ? H_ACK : H_READY;
                  cnt_q  <= '0;
                  pull_q <= 1'b0;
               end
            H_ACK:
               if ((ackSeen_q && pinSync_q)
                   || (!ackSeen_q && cnt_q >= CNT_W'(ACK_WATCH_CYC)))
                  st_q <= H_READY;
            default:
               st_q <= H_OFF;
         endcase
      end
   end

   assign link.hostPullLow = pull_q;
   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;

endmodule
`default_nettype wire

// >>> design/dimming_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dimming_link_if;
   logic hostPullLow;
   logic devPullLow;
   logic pinLevel;

   // Open-drain wire with pull-up: low whenever either end pulls
   assign pinLevel = ~(hostPullLow | devPullLow);

   modport device (input pinLevel, output devPullLow);
   modport host   (input pinLevel, output hostPullLow);
endinterface
`default_nettype wire

// >>> tb/dimming_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dimming_link_asserts #(
   parameter int ACK_CYC = 300
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic hostPullLow,
   input wire logic devPullLow,
   input wire logic pinLevel
);
   logic [15:0] ackRun_q;
   logic [15:0] highRun_q;
   logic [7:0]  falls_q;
   logic        pin_q;

   // --------
   // Run counters; high and fall counts saturate so idle stretches cannot wrap, ack count does not
   // --------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ackRun_q  <= 16'h0000;
         highRun_q <= 16'h0000;
         falls_q   <= 8'h00;
         pin_q     <= 1'b0;
      end
      else
      begin
         ackRun_q  <= devPullLow ? ackRun_q + 16'h0001 : 16'h0000;
         highRun_q <= pinLevel ? highRun_q + {15'h0000, ~&highRun_q} : 16'h0000;
         falls_q   <= devPullLow ? 8'h00 : falls_q + {7'h00, pin_q & ~pinLevel & ~&falls_q};
         pin_q     <= pinLevel;
      end
   end

   // --------
   // Wire checks
   // --------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_wire_level:
   assert property ($fell(devPullLow) |-> pinLevel [*4]) else $error("pin held after ack");
   a_no_contention:
   assert property (devPullLow |-> !hostPullLow) else $error("both ends pull");
   a_host_holds_low:
   assert property ($fell(reset) |-> hostPullLow [*8]) else $error("host released early");
   a_dev_quiet:
   assert property ($fell(reset) |-> !devPullLow) else $error("device pulls after reset");
   a_ack_length:
   assert property ($fell(devPullLow) |-> ackRun_q == ACK_CYC) else $error("ack length");
   a_ack_steady:
   assert property ($rose(devPullLow) |=> devPullLow [*8]) else $error("ack glitch");
   a_ack_gap:
   assert property ($rose(devPullLow) |-> highRun_q >= 150 && highRun_q <= 175)
      else $error("ack gap");
   a_ack_whole_frame:
   assert property ($rose(devPullLow) |-> falls_q >= 8'h11) else $error("ack without frame");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dim_pkg::*;
   localparam int WIN  = 5000;
   localparam int SHDN = 4000;
   localparam int ACKC = 300;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        active;
   logic        oneWire;
   logic [4:0]  stepCode;
   logic [7:0]  refMv;
   logic [31:0] rd;
   logic        err;
   logic [4:0]  codes [7] = '{5'h00, 5'h1F, 5'h01, 5'h0C, 5'h17, 5'h18, 5'h0D};
   int          fails = 0;
   int          checks = 0;
   int          hi;

   dimming_link_if link ();
   dimming_host #(.SHDN_CYC(SHDN)) dimming_host_inst (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   dimming_device #(.WIN_CYC(WIN), .SHDN_CYC(SHDN), .ACK_CYC(ACKC)) dimming_device_inst (
      .clk(clk), .reset(reset), .link(link), .active(active), .oneWire(oneWire),
      .stepCode(stepCode), .refMv(refMv));
   dimming_link_asserts #(.ACK_CYC(ACKC)) dimming_link_asserts_inst (.clk(clk),
      .reset(reset), .hostPullLow(link.hostPullLow), .devPullLow(link.devPullLow),
      .pinLevel(link.pinLevel));

   always #50 clk = ~clk;

   // --------
   // Bus and compare tasks
   // --------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave's answer
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Status polls are bounded so a stuck busy flag ends as a mismatch
   task poll(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, STATUS_OFS, 32'h0000_0000);
         n++;
      end
      while (rd[b] !== v && n < 3000);
      if (n >= 3000) fails++;
   endtask

   function automatic logic [7:0] mv(input logic [4:0] c);
      logic [7:0] v;
      v = {3'h0, c};
      if (v == 8'h00) return 8'h00;
      if (v <= 8'h0C) return 8'h05 + 8'h03 * (v - 8'h01);
      if (v <= 8'h17) return 8'h26 + 8'h06 * (v - 8'h0C);
      return 8'h68 + 8'h0C * (v - 8'h17);
   endfunction

   task cmd(input logic [7:0] d, input logic [4:0] s, input logic ack);
      apb(1'b1, CMD_OFS, {24'h00_0000, d});
      poll(0, 1'b0);
      chk(32'(stepCode), 32'(s));
      chk(32'(refMv), 32'(mv(s)));
      chk(32'(rd[1]), 32'(ack));
   endtask

   task give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // --------
   // Tests
   // --------
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(32'(stepCode), 32'h0000_001F);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, CTRL_OFS, 32'h0000_FF01);
      repeat (SHDN + WIN + 200) @(posedge clk);
      chk(32'(active), 32'h0000_0001);
      chk(32'(oneWire), 32'h0000_0000);
      chk(32'(refMv), 32'h0000_00C8);
      apb(1'b1, CTRL_OFS, 32'h0000_8005);
      hi = 0;
      repeat (1024)
      begin
         @(posedge clk);
         hi += (refMv === 8'hC8);
      end
      chk(32'(hi >= 480 && hi <= 544), 32'h0000_0001);
      chk(32'(oneWire), 32'h0000_0000);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk(32'(rd[3]), 32'h0000_0001);
      $display("test pwm done");
      apb(1'b1, CTRL_OFS, 32'h0000_FF00);
      repeat (SHDN + 50) @(posedge clk);
      chk({active, refMv, link.pinLevel}, 32'h0000_0000);
      apb(1'b1, CTRL_OFS, 32'h0000_FF03);
      poll(2, 1'b1);
      chk(32'(oneWire), 32'h0000_0001);
      chk(32'(refMv), 32'h0000_00C8);
      $display("test entry done");
      for (int i = 0; i < 7; i++)
         cmd({i[0], 2'b00, codes[i]}, codes[i], i[0]);
      cmd(8'hA5, 5'h0D, 1'b0);
      $display("test commands done");
      apb(1'b1, CTRL_OFS, 32'h0000_FF00);
      repeat (SHDN + 50) @(posedge clk);
      apb(1'b1, CTRL_OFS, 32'h0000_FF01);
      repeat (SHDN + WIN + 200) @(posedge clk);
      chk({oneWire, stepCode, refMv}, 32'h0000_0DC8);
      reset <= 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk({active, stepCode}, 32'h0000_001F);
      $display("test restart done");
      give_verdict;
   end

   initial
   begin
      repeat (95000) @(posedge clk);
      fails++;
      give_verdict;
   end
endmodule
`default_nettype wire
